// [logic/svb_atomic_alu.sv]
module svb_atomic_alu
	import svb_pkg::*;
(
	input wire svb_op_t op,
	input wire logic [15:0] old_val,
	input wire logic [15:0] operand,
	input wire logic [15:0] cmp,
	output logic [15:0] new_val,
	output logic do_write
);
	// Operands are 16 bits only; wider atomics are not supported.
	always_comb begin
		new_val = old_val;
		do_write = 1'b1;
		unique case (op)
			SW_ADD: new_val = 16'(old_val + operand);
			SW_AND: new_val = old_val & operand;
			SW_IOR: new_val = old_val | operand;
			SW_ATOMIC_COMPARE_AND_SWAP: begin
				do_write = (old_val == cmp);
				new_val = operand;
			end
			default: do_write = 1'b0;
		endcase
	end
endmodule : svb_atomic_alu

// [logic/svb_bridge.sv]
// Notes on behaviour
// - Sixty-four mapping registers; entries 1 to 63 translate switch windows to VME address and modifier.
// - Mapping register 0 hits local bank 0; the VMEbus stays idle.
// - Atomic add/and/or/compare-swap hold the VMEbus locked from read to write.
// - Atomic operations act on 16-bit operands only.
// - Queue operations are refused; plain and atomic operations pass.
// - Interrupt request control value is copied into interrupter vector and request when its request field is nonzero.
// - Host can read back interrupter vector and request registers.
// - One event control register per VME level and per four internal conditions.
// - Zero event register means the firing source is ignored.
// - Nonzero event register is posted as event handle over the switch.
// - Posted data word is the vector obtained from the VMEbus, or zero for internal conditions.
// - Event register clears to zero after posting.
// - Interrupt acknowledge cycle only for VME sources, never internal ones.
// - Nonzero handle enables a source, zero disables it.
// - All control registers are readable and writable by the host.
// - Translation gives full 32-bit address and six modifier bits.
// - Reads return VME data to the requester; writes end on the bus.
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
module svb_bridge
	import svb_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire svb_sw_req_t sw_req,
	input wire logic sw_req_valid,
	output logic sw_req_ready,
	output svb_sw_rsp_t sw_rsp,
	output logic sw_rsp_valid,
	output svb_post_t post,
	output logic post_valid,
	output svb_vme_req_t vme_req,
	output logic vme_req_valid,
	input wire logic [31:0] vme_rdata,
	input wire logic vme_done,
	output logic vme_lock,
	input wire logic [6:0] vme_irq,
	input wire logic [3:0] int_cond,
	output logic [2:0] vme_iack_level,
	output logic vme_iack_valid,
	input wire logic [7:0] vme_iack_vector,
	input wire logic vme_iack_done,
	output logic [7:0] irq_vector,
	output logic [6:0] irq_request
);
	////////////////////////////////////////////////////////////////////////////
	// Register file
	logic [31:0] map_addr_r [MAP_COUNT];
	logic [5:0] map_mod_r [MAP_COUNT];
	logic [31:0] evt_r [EVT_COUNT];
	logic [31:0] bank0_r [BANK0_WORDS];
	logic [31:0] irq_ctrl_r;
	logic [31:0] ctrl_r;
	logic [11:0] awaddr_r;
	logic aw_have_r, w_have_r, bvalid_r, rvalid_r;
	logic [31:0] wdata_r, rdata_r;
	logic [1:0] rresp_r, bresp_r;
	logic arready_r;

	// Engine state
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_BUS = 3'b001,
		ST_RMW_WR = 3'b010,
		ST_RESP = 3'b011,
		ST_IACK = 3'b100,
		ST_POST = 3'b101
	} svb_state_t;
	svb_state_t st_r, st_nxt;
	svb_sw_req_t req_r, req_nxt;
	svb_vme_req_t vreq_r, vreq_nxt;
	logic vvalid_r, vvalid_nxt, lock_r, lock_nxt;
	svb_sw_rsp_t rsp_r, rsp_nxt;
	logic rsp_valid_r, rsp_valid_nxt, sw_ready_r, sw_ready_nxt;
	svb_post_t post_r, post_nxt;
	logic post_valid_r, post_valid_nxt;
	logic [2:0] iack_lvl_r, iack_lvl_nxt;
	logic iack_valid_r, iack_valid_nxt;
	logic [3:0] src_r, src_nxt;
	logic clr_evt;
	logic [7:0] irq_vec_r;
	logic [6:0] irq_req_r;

	logic wr_fire, rd_fire;
	logic [31:0] rd_val;
	logic [1:0] rd_resp;
	logic [15:0] alu_new;
	logic alu_wr;
	logic sw_take, ev_hit;
	logic [10:0] fire_vec;

	assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
	assign rd_fire = s_axi_arvalid && arready_r;
	assign sw_take = sw_req_valid && sw_ready_r;

	always_comb begin
		rd_val = RESET_ZERO;
		rd_resp = RESP_OKAY;
		if (s_axi_araddr == OFS_CTRL) rd_val = ctrl_r;
		else if (s_axi_araddr == OFS_STATUS) rd_val = {29'h0, st_r};
		else if (s_axi_araddr == OFS_IRQ_REQ) rd_val = irq_ctrl_r;
		else if (s_axi_araddr == OFS_IRQ_RB) rd_val = {17'h0, irq_req_r, irq_vec_r};
		else if (s_axi_araddr >= OFS_EVT_BASE && s_axi_araddr < OFS_EVT_BASE + 12'h02C)
			rd_val = evt_r[4'(s_axi_araddr[5:2] - 4'h0)];
		else if (s_axi_araddr[11:10] == OFS_MAP_ADDR_BASE[11:10])
			rd_val = map_addr_r[s_axi_araddr[7:2]];
		else if (s_axi_araddr[11:10] == OFS_MAP_MOD_BASE[11:10])
			rd_val = {26'h0, map_mod_r[s_axi_araddr[7:2]]};
		else if (s_axi_araddr[11:10] == OFS_BANK0_BASE[11:10])
			rd_val = bank0_r[s_axi_araddr[9:2]];
		else rd_resp = RESP_SLVERR;
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) if (st[b]) r[b*8 +: 8] = nw[b*8 +: 8];
		return r;
	endfunction : merge

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			arready_r <= 1'b0;
			rdata_r <= RESET_ZERO;
			rresp_r <= RESP_OKAY;
			awaddr_r <= 12'h000;
			wdata_r <= RESET_ZERO;
			ctrl_r <= RESET_ZERO;
			irq_ctrl_r <= RESET_ZERO;
			irq_vec_r <= 8'h00;
			irq_req_r <= 7'h00;
			for (int i = 0; i < MAP_COUNT; i++) begin
				map_addr_r[i] <= RESET_ZERO;
				map_mod_r[i] <= MOD_RESET;
			end
			for (int i = 0; i < EVT_COUNT; i++) evt_r[i] <= RESET_ZERO;
			for (int i = 0; i < BANK0_WORDS; i++) bank0_r[i] <= RESET_ZERO;
		end else begin
			if (s_axi_awvalid && !aw_have_r) begin
				aw_have_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_have_r) begin
				w_have_r <= 1'b1;
				wdata_r <= merge(32'h0, s_axi_wdata, s_axi_wstrb);
			end
			arready_r <= s_axi_arvalid && !arready_r && !rvalid_r;
			if (rd_fire) begin
				rvalid_r <= 1'b1;
				rdata_r <= rd_val;
				rresp_r <= rd_resp;
			end else if (s_axi_rready) rvalid_r <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) bvalid_r <= 1'b0;
			// Interrupter copy of the request control value
			if (irq_ctrl_r[14:8] != 7'h00) begin
				irq_vec_r <= irq_ctrl_r[7:0];
				irq_req_r <= irq_ctrl_r[14:8];
			end
			// Engine clear first so a host write in the same cycle wins
			if (clr_evt) evt_r[src_r] <= RESET_ZERO;
			if (wr_fire) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= RESP_OKAY;
				if (awaddr_r == OFS_CTRL) ctrl_r <= wdata_r;
				else if (awaddr_r == OFS_IRQ_REQ) irq_ctrl_r <= wdata_r;
				else if (awaddr_r >= OFS_EVT_BASE && awaddr_r < OFS_EVT_BASE + 12'h02C)
					evt_r[awaddr_r[5:2]] <= wdata_r;
				else if (awaddr_r[11:10] == OFS_MAP_ADDR_BASE[11:10])
					map_addr_r[awaddr_r[7:2]] <= wdata_r;
				else if (awaddr_r[11:10] == OFS_MAP_MOD_BASE[11:10])
					map_mod_r[awaddr_r[7:2]] <= wdata_r[5:0];
				else if (awaddr_r[11:10] == OFS_BANK0_BASE[11:10])
					bank0_r[awaddr_r[9:2]] <= wdata_r;
				else if (awaddr_r != OFS_STATUS && awaddr_r != OFS_IRQ_RB)
					bresp_r <= RESP_SLVERR;
			end
			// Local bank 0 plain writes from the switch side
			if (st_r == ST_IDLE && sw_take
					&& sw_req.addr[WIN_SHIFT+MAP_IDX_W-1:WIN_SHIFT] == 6'h00
					&& sw_req.op == SW_WRITE)
				bank0_r[sw_req.addr[9:2]] <= sw_req.wdata;
		end
	end

	assign s_axi_awready = !aw_have_r;
	assign s_axi_wready = !w_have_r;

	////////////////////////////////////////////////////////////////////////////
	// Switch and interrupt engine
	svb_atomic_alu u_alu (
		.op(req_r.op),
		.old_val(rsp_r.data[15:0]),
		.operand(req_r.wdata[15:0]),
		.cmp(req_r.cmp),
		.new_val(alu_new),
		.do_write(alu_wr)
	);

	// VME levels 1..7 in slots 0..6, internal conditions in 7..10
	assign fire_vec = {int_cond, vme_irq};

	always_comb begin
		st_nxt = st_r;
		req_nxt = req_r;
		vreq_nxt = vreq_r;
		vvalid_nxt = 1'b0;
		lock_nxt = lock_r;
		rsp_nxt = rsp_r;
		rsp_valid_nxt = 1'b0;
		sw_ready_nxt = 1'b0;
		post_nxt = post_r;
		post_valid_nxt = 1'b0;
		iack_lvl_nxt = iack_lvl_r;
		iack_valid_nxt = 1'b0;
		src_nxt = src_r;
		clr_evt = 1'b0;
		ev_hit = 1'b0;
		unique case (st_r)
			ST_IDLE: begin
				sw_ready_nxt = ctrl_r[CTRL_EN_BIT];
				// Sources with zero handles are skipped and never acknowledged
				for (int i = EVT_COUNT - 1; i >= 0; i--) begin
					if (fire_vec[i] && evt_r[i] != RESET_ZERO) begin
						src_nxt = 4'(i);
						ev_hit = 1'b1;
					end
				end
				if (ev_hit) sw_ready_nxt = 1'b0;
				// A request already handshaken is served first so it is never lost
				if (sw_take) begin
					req_nxt = sw_req;
					rsp_nxt.dst_node = sw_req.src_node;
					rsp_nxt.err = 1'b0;
					rsp_nxt.data = RESET_ZERO;
					if (sw_req.op == SW_QUEUE) begin
						rsp_nxt.err = 1'b1;
						st_nxt = ST_RESP;
					end else if (sw_req.addr[WIN_SHIFT+MAP_IDX_W-1:WIN_SHIFT] == 6'h00) begin
						rsp_nxt.data = bank0_r[sw_req.addr[9:2]];
						st_nxt = ST_RESP;
					end else begin
						vreq_nxt.addr = map_addr_r[sw_req.addr[WIN_SHIFT+MAP_IDX_W-1:WIN_SHIFT]]
							+ {16'h0, sw_req.addr[WIN_SHIFT-1:0]};
						vreq_nxt.am = map_mod_r[sw_req.addr[WIN_SHIFT+MAP_IDX_W-1:WIN_SHIFT]];
						vreq_nxt.write = (sw_req.op == SW_WRITE);
						vreq_nxt.wdata = sw_req.wdata;
						vreq_nxt.rmw = (sw_req.op != SW_READ && sw_req.op != SW_WRITE);
						lock_nxt = vreq_nxt.rmw;
						vvalid_nxt = 1'b1;
						st_nxt = ST_BUS;
					end
				end else if (ev_hit) begin
					if (src_nxt < 4'(VME_LEVELS)) begin
						iack_lvl_nxt = 3'(src_nxt + 4'h1);
						iack_valid_nxt = 1'b1;
						st_nxt = ST_IACK;
					end else begin
						post_nxt.handle = evt_r[src_nxt];
						post_nxt.vector = RESET_ZERO;
						st_nxt = ST_POST;
					end
				end
			end
			ST_BUS: begin
				vvalid_nxt = !vme_done;
				if (vme_done) begin
					if (vreq_r.rmw && !vreq_r.write) begin
						rsp_nxt.data = vme_rdata;
						st_nxt = ST_RMW_WR;
					end else if (vreq_r.rmw) begin
						// Old value stays as the answer; the lock drops on the way out
						st_nxt = ST_RESP;
					end else begin
						rsp_nxt.data = vreq_r.write ? RESET_ZERO : vme_rdata;
						st_nxt = vreq_r.write ? ST_IDLE : ST_RESP;
					end
				end
			end
			ST_RMW_WR: begin
				// Lock held from read through write keeps the sequence indivisible
				if (alu_wr && !vvalid_r) begin
					vreq_nxt.write = 1'b1;
					vreq_nxt.wdata = {16'h0, alu_new};
					vvalid_nxt = 1'b1;
					st_nxt = ST_BUS;
				end else begin
					lock_nxt = 1'b0;
					st_nxt = ST_RESP;
				end
			end
			ST_RESP: begin
				rsp_valid_nxt = 1'b1;
				lock_nxt = 1'b0;
				st_nxt = ST_IDLE;
			end
			ST_IACK: begin
				iack_valid_nxt = !vme_iack_done;
				if (vme_iack_done) begin
					post_nxt.handle = evt_r[src_r];
					post_nxt.vector = {24'h0, vme_iack_vector};
					st_nxt = ST_POST;
				end
			end
			ST_POST: begin
				post_valid_nxt = 1'b1;
				clr_evt = 1'b1;
				st_nxt = ST_IDLE;
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r <= ST_IDLE;
			req_r <= '0;
			vreq_r <= '0;
			vvalid_r <= 1'b0;
			lock_r <= 1'b0;
			rsp_r <= '0;
			rsp_valid_r <= 1'b0;
			sw_ready_r <= 1'b0;
			post_r <= '0;
			post_valid_r <= 1'b0;
			iack_lvl_r <= 3'h0;
			iack_valid_r <= 1'b0;
			src_r <= 4'h0;
		end else begin
			st_r <= st_nxt;
			req_r <= req_nxt;
			vreq_r <= vreq_nxt;
			vvalid_r <= vvalid_nxt;
			lock_r <= lock_nxt;
			rsp_r <= rsp_nxt;
			rsp_valid_r <= rsp_valid_nxt;
			sw_ready_r <= sw_ready_nxt && !sw_take;
			post_r <= post_nxt;
			post_valid_r <= post_valid_nxt;
			iack_lvl_r <= iack_lvl_nxt;
			iack_valid_r <= iack_valid_nxt;
			src_r <= src_nxt;
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign sw_req_ready = sw_ready_r;
	assign sw_rsp = rsp_r;
	assign sw_rsp_valid = rsp_valid_r;
	assign post = post_r;
	assign post_valid = post_valid_r;
	assign vme_req = vreq_r;
	assign vme_req_valid = vvalid_r;
	assign vme_lock = lock_r;
	assign vme_iack_level = iack_lvl_r;
	assign vme_iack_valid = iack_valid_r;
	assign irq_vector = irq_vec_r;
	assign irq_request = irq_req_r;
endmodule : svb_bridge

// [logic/svb_pkg.sv]
package svb_pkg;
	// Register byte offsets (AXI4-Lite word aligned)
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_IRQ_REQ = 12'h008;
	localparam logic [11:0] OFS_IRQ_RB = 12'h00C;
	localparam logic [11:0] OFS_EVT_BASE = 12'h040;
	localparam logic [11:0] OFS_MAP_ADDR_BASE = 12'h400;
	localparam logic [11:0] OFS_MAP_MOD_BASE = 12'h800;
	localparam logic [11:0] OFS_BANK0_BASE = 12'hC00;
	localparam int MAP_COUNT = 64;
	localparam int EVT_COUNT = 11;
	localparam int VME_LEVELS = 7;
	localparam int BANK0_WORDS = 256;
	localparam int WIN_SHIFT = 16;
	localparam int MAP_IDX_W = 6;
	localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
	localparam logic [5:0] MOD_RESET = 6'h00;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam int CTRL_EN_BIT = 0;

	typedef enum logic [2:0] {
		SW_READ = 3'b000,
		SW_WRITE = 3'b001,
		SW_ADD = 3'b010,
		SW_AND = 3'b011,
		SW_IOR = 3'b100,
		SW_ATOMIC_COMPARE_AND_SWAP = 3'b101,
		SW_QUEUE = 3'b110
	} svb_op_t;

	typedef struct packed {
		svb_op_t op;
		logic [21:0] addr;
		logic [31:0] wdata;
		logic [15:0] cmp;
		logic [7:0] src_node;
	} svb_sw_req_t;

	typedef struct packed {
		logic [31:0] data;
		logic [7:0] dst_node;
		logic err;
	} svb_sw_rsp_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [5:0] am;
		logic write;
		logic [31:0] wdata;
		logic rmw;
	} svb_vme_req_t;

	typedef struct packed {
		logic [31:0] handle;
		logic [31:0] vector;
	} svb_post_t;
endpackage : svb_pkg

// [sim/svb_bridge_chk.sv]
module svb_bridge_chk
	import svb_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire svb_sw_req_t sw_req,
	input wire logic sw_req_valid,
	input wire logic sw_req_ready,
	input wire svb_vme_req_t vme_req,
	input wire logic vme_req_valid,
	input wire logic vme_done,
	input wire logic vme_lock,
	input wire logic [6:0] vme_irq,
	input wire logic [2:0] vme_iack_level,
	input wire logic vme_iack_valid,
	input wire logic vme_iack_done,
	input wire svb_post_t post,
	input wire logic post_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic take;
	assign take = sw_req_valid && sw_req_ready;
	////////////////////////////////
	AST_BANK0_QUIET: assert property (
		take && sw_req.addr[21:16] == 6'h00 |=> !vme_req_valid [*2])
		else $error("bank0 access reached the bus");
	AST_QUEUE_QUIET: assert property (
		take && sw_req.op == SW_QUEUE |=> !vme_req_valid [*2])
		else $error("queue access reached the bus");
	AST_REQ_HOLD: assert property (
		vme_req_valid && !vme_done |=> vme_req_valid && $stable(vme_req))
		else $error("bus request changed early");
	AST_LOCK: assert property (
		vme_req_valid && vme_req.rmw |-> vme_lock)
		else $error("atomic access unlocked");
	AST_LOCK_SPAN: assert property (
		vme_req_valid && vme_req.rmw && vme_req.write |-> $past(vme_lock))
		else $error("lock gap before atomic write");
	AST_POST_HANDLE: assert property (
		post_valid |-> post.handle != 32'h0)
		else $error("post with zero handle");
	AST_IACK_CAUSE: assert property (
		$rose(vme_iack_valid) |-> vme_irq[vme_iack_level - 3'd1])
		else $error("acknowledge without request");
	AST_IACK_HOLD: assert property (
		vme_iack_valid && !vme_iack_done |=> vme_iack_valid && $stable(vme_iack_level))
		else $error("acknowledge dropped early");
	AST_IACK_POST: assert property (
		vme_iack_valid && vme_iack_done |-> ##[0:8] post_valid)
		else $error("no post after acknowledge");
endmodule : svb_bridge_chk

bind svb_bridge svb_bridge_chk svb_bridge_chk_i (
	.clk, .rst_n, .sw_req, .sw_req_valid, .sw_req_ready, .vme_req, .vme_req_valid,
	.vme_done, .vme_lock, .vme_irq, .vme_iack_level, .vme_iack_valid, .vme_iack_done,
	.post, .post_valid
);

// [sim/svb_vme_model.sv]
module svb_vme_model
	import svb_pkg::*;
(
	input wire logic clk,
	input wire logic slow,
	input wire svb_vme_req_t vme_req,
	input wire logic vme_req_valid,
	output logic [31:0] vme_rdata,
	output logic vme_done,
	input wire logic [2:0] vme_iack_level,
	input wire logic vme_iack_valid,
	output logic [7:0] vme_iack_vector,
	output logic vme_iack_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [16];
	logic [31:0] last_addr;
	logic [5:0] last_am;
	int cnt = 0;
	initial begin
		for (int i = 0; i < 16; i++) begin
			mem[i] = 32'h5A5A_0000 + 32'(i);
		end
		vme_rdata = 32'h0;
		vme_done = 1'b0;
		vme_iack_vector = 8'h00;
		vme_iack_done = 1'b0;
	end
	////////////////////////////////
	// Idle data lines toggle so a stale word is never taken for an answer
	always @(posedge clk) begin
		vme_done <= 1'b0;
		vme_iack_done <= 1'b0;
		vme_rdata <= ~vme_rdata;
		vme_iack_vector <= ~vme_iack_vector;
		if ((vme_req_valid && !vme_done) || (vme_iack_valid && !vme_iack_done))
			cnt <= cnt + 1;
		if (vme_req_valid && !vme_done && cnt >= (slow ? 5 : 1)) begin
			cnt <= 0;
			vme_done <= 1'b1;
			last_addr <= vme_req.addr;
			last_am <= vme_req.am;
			if (vme_req.write)
				mem[vme_req.addr[5:2]] <= vme_req.wdata;
			else
				vme_rdata <= mem[vme_req.addr[5:2]];
		end
		if (vme_iack_valid && !vme_iack_done && cnt >= 1) begin
			cnt <= 0;
			vme_iack_done <= 1'b1;
			vme_iack_vector <= {5'b10100, vme_iack_level};
		end
	end
endmodule : svb_vme_model

// [sim/testbench.sv]
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import svb_pkg::*;
	logic clk, rst_n, slow;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, vme_rdata;
	logic [3:0] s_axi_wstrb, int_cond;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	svb_sw_req_t sw_req;
	svb_sw_rsp_t sw_rsp;
	svb_post_t post, post_seen;
	svb_vme_req_t vme_req;
	logic sw_req_valid, sw_req_ready, sw_rsp_valid, post_valid, vme_req_valid;
	logic vme_done, vme_lock, vme_iack_valid, vme_iack_done;
	logic [6:0] vme_irq, irq_request;
	logic [2:0] vme_iack_level, iack_lvl;
	logic [7:0] vme_iack_vector, irq_vector;
	int err_count = 0;
	int comparisons = 0;
	int post_cnt = 0;
	int iack_cnt = 0;
	svb_bridge svb_bridge_i (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sw_req, .sw_req_valid, .sw_req_ready,
		.sw_rsp, .sw_rsp_valid, .post, .post_valid, .vme_req, .vme_req_valid, .vme_rdata,
		.vme_done, .vme_lock, .vme_irq, .int_cond, .vme_iack_level, .vme_iack_valid,
		.vme_iack_vector, .vme_iack_done, .irq_vector, .irq_request);
	svb_vme_model svb_vme_model_i (.clk, .slow, .vme_req, .vme_req_valid, .vme_rdata,
		.vme_done, .vme_iack_level, .vme_iack_valid, .vme_iack_vector, .vme_iack_done);
	////////////////////////////////
	task automatic check_val(input string nm, input logic [63:0] e, input logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : check_val
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : stop_test
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
	endtask : axi_wr
	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : axi_rd
	// Writes through a window get no answer, so one spare edge keeps valid from toggling twice in a step
	task automatic sw_op(input svb_op_t op, input logic [21:0] a, input logic [31:0] d,
			input logic [15:0] c, input bit want, output svb_sw_rsp_t s);
		sw_req <= '{op, a, d, c, 8'h2C};
		sw_req_valid <= 1'b1;
		do @(posedge clk); while (!sw_req_ready);
		sw_req_valid <= 1'b0;
		if (want) do @(posedge clk); while (!sw_rsp_valid);
		else @(posedge clk);
		s = sw_rsp;
	endtask : sw_op
	always @(posedge clk) begin
		if (post_valid) begin
			post_seen <= post;
			post_cnt <= post_cnt + 1;
		end
		if (vme_iack_valid && vme_iack_done) begin
			iack_cnt <= iack_cnt + 1;
			iack_lvl <= vme_iack_level;
		end
	end
	////////////////////////////////
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < EVT_COUNT; i++) begin
			axi_rd(OFS_EVT_BASE + 12'(4 * i), d, r);
			check_val("event reset", 64'h0, {32'h0, d});
		end
		axi_wr(OFS_EVT_BASE + 12'h028, 32'h0000_C0DE, r);
		axi_rd(OFS_EVT_BASE + 12'h028, d, r);
		check_val("event readback", 64'hC0DE, {32'h0, d});
		axi_wr(OFS_EVT_BASE + 12'h028, 32'h0, r);
		axi_rd(12'h010, d, r);
		check_val("unmapped resp", {62'h0, RESP_SLVERR}, {62'h0, r});
		axi_wr(12'h010, 32'h1, r);
		check_val("unmapped wr resp", {62'h0, RESP_SLVERR}, {62'h0, r});
		axi_wr(OFS_CTRL, 32'h1, r);
		check_val("ctrl wr resp", {62'h0, RESP_OKAY}, {62'h0, r});
		// Window 5 is one whole 64 KB unit; entry 1 stays free for single accesses
		axi_wr(OFS_MAP_ADDR_BASE + 12'h014, 32'hABCD_0000, r);
		axi_wr(OFS_MAP_MOD_BASE + 12'h014, 32'h3D, r);
		axi_rd(OFS_MAP_MOD_BASE + 12'h014, d, r);
		check_val("modifier", 64'h3D, {32'h0, d});
		check_val("modifier resp", {62'h0, RESP_OKAY}, {62'h0, r});
		$display("register test done");
	endtask : t_regs
	task automatic t_access();
		svb_sw_rsp_t s;
		sw_op(SW_WRITE, 22'h00_0010, 32'h600D_F00D, 16'h0, 1'b0, s);
		sw_op(SW_READ, 22'h00_0010, 32'h0, 16'h0, 1'b1, s);
		check_val("bank0 data", 64'h600D_F00D, {32'h0, s.data});
		slow <= 1'b1;
		sw_op(SW_READ, 22'h05_0008, 32'h0, 16'h0, 1'b1, s);
		check_val("map read", 64'h5A5A_0002, {32'h0, s.data});
		check_val("rsp node", 64'h2C, {56'h0, s.dst_node});
		check_val("vme addr", {26'h0, 32'hABCD_0008, 6'h3D},
			{26'h0, svb_vme_model_i.last_addr, svb_vme_model_i.last_am});
		sw_op(SW_WRITE, 22'h05_000C, 32'h1234_5678, 16'h0, 1'b0, s);
		sw_op(SW_READ, 22'h05_000C, 32'h0, 16'h0, 1'b1, s);
		check_val("map write", 64'h1234_5678, {32'h0, s.data});
		slow <= 1'b0;
		$display("access test done");
	endtask : t_access
	task automatic t_atomic();
		svb_sw_rsp_t s;
		svb_op_t ops [6] = '{SW_ADD, SW_AND, SW_IOR, SW_ATOMIC_COMPARE_AND_SWAP,
			SW_ATOMIC_COMPARE_AND_SWAP, SW_QUEUE};
		logic [15:0] cmps [6] = '{16'h0, 16'h0, 16'h0, 16'h00F0, 16'h1111, 16'h0};
		logic [15:0] exps [6] = '{16'h00FF, 16'h0000, 16'h00FF, 16'h000F, 16'h00F0, 16'h00F0};
		for (int i = 0; i < 6; i++) begin
			sw_op(SW_WRITE, 22'h05_0010, 32'h0000_00F0, 16'h0, 1'b0, s);
			sw_op(ops[i], 22'h05_0010, 32'h0000_000F, cmps[i], 1'b1, s);
			if (i == 5) check_val("queue err", 64'h1, {63'h0, s.err});
			sw_op(SW_READ, 22'h05_0010, 32'h0, 16'h0, 1'b1, s);
			check_val("atomic", {48'h0, exps[i]}, {48'h0, s.data[15:0]});
		end
		$display("atomic test done");
	endtask : t_atomic
	task automatic t_irq();
		logic [31:0] d;
		logic [1:0] r;
		axi_wr(OFS_IRQ_REQ, 32'h0000_0433, r);
		while (irq_request === 7'h00) @(posedge clk);
		check_val("irq out", 64'h0433, {49'h0, irq_request, irq_vector});
		axi_rd(OFS_IRQ_RB, d, r);
		check_val("irq readback", 64'h0433, {49'h0, d[14:0]});
		vme_irq <= 7'h04;
		repeat (20) @(posedge clk);
		check_val("ignored irq", 64'h0, {32'(post_cnt), 32'(iack_cnt)});
		axi_wr(OFS_EVT_BASE + 12'h008, 32'h0000_BEEF, r);
		while (post_cnt == 0) @(posedge clk);
		vme_irq <= 7'h00;
		check_val("vme post", 64'h0000_BEEF_0000_00A3, post_seen);
		check_val("iack", 64'h0000_0001_0000_0003, {32'(iack_cnt), 29'h0, iack_lvl});
		axi_rd(OFS_EVT_BASE + 12'h008, d, r);
		check_val("event cleared", 64'h0, {32'h0, d});
		axi_wr(OFS_EVT_BASE + 12'h020, 32'h0000_0077, r);
		int_cond <= 4'h2;
		while (post_cnt == 1) @(posedge clk);
		int_cond <= 4'h0;
		check_val("int post", 64'h0000_0077_0000_0000, post_seen);
		check_val("int no iack", 64'h1, 64'(iack_cnt));
		$display("interrupt test done");
	endtask : t_irq
	////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		stop_test();
	end
	initial begin
		rst_n = 1'b0;
		slow = 1'b0;
		s_axi_awaddr = 12'h000;
		s_axi_araddr = 12'h000;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		sw_req = '0;
		sw_req_valid = 1'b0;
		vme_irq = 7'h00;
		int_cond = 4'h0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_regs();
		t_access();
		t_atomic();
		t_irq();
		stop_test();
	end
endmodule : testbench
